// [core/epw_cfg.svh]
// Purpose: constants for the eight channel pulse width modulator
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef EPW_CFG_SVH
`define EPW_CFG_SVH
`define EPW_ADDR_W         16
`define EPW_PRESCALE_ADDR  16'hFD00
`define EPW_CYCLE_ADDR     16'hFD04
`define EPW_DUTY0_ADDR     16'hFD08
`define EPW_POLARITY_ADDR  16'hFD28
`define EPW_CONTROL_ADDR   16'hFD2C
`define EPW_PRESCALE_RST   8'h00
`define EPW_CYCLE_RST      8'hFF
`define EPW_DUTY_RST       8'h00
`define EPW_POLARITY_RST   8'h00
`define EPW_PWR_RST        1'b0
`define EPW_PWR_BIT        0
`define EPW_RESP_OKAY      2'h0
`define EPW_RESP_SLVERR    2'h2
`endif

// [core/epw_pkg.sv]
// Purpose: types for the eight channel pulse width modulator
// Assumes: constants come from epw_cfg.svh
// Notes:   control fields travel together as one struct
package epw_pkg;
    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] cycle;
        logic [7:0] polarity;
        logic       power_mode_bit;
    } epw_ctl_t;

    typedef enum logic [2:0] {
        EPW_R_PRESCALE,
        EPW_R_CYCLE,
        EPW_R_DUTY,
        EPW_R_POLARITY,
        EPW_R_CONTROL,
        EPW_R_NONE
    } epw_reg_t;
endpackage : epw_pkg

// [core/epw_top.sv]
// Purpose: eight output pulse width modulator with AXI4-Lite registers
// Assumes: one clock, synchronous active high reset
// Notes:   outputs and bus answers are all registered
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "epw_cfg.svh"

module epw_top
    import epw_pkg::*;
#(
    parameter int NUM_OUT = 8,
    parameter int ADDR_W  = `EPW_ADDR_W
) (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata_o,
    output logic [1:0]                s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i,
    // Modulated outputs
    output logic [NUM_OUT-1:0]        pulse_out_o
);

    epw_ctl_t             ctl_q;
    logic [7:0]           duty_value_q [NUM_OUT];
    logic [7:0]           pre_cnt_q;
    logic [7:0]           cnt_q;
    logic                 tick;
    logic [NUM_OUT-1:0]   raw;
    logic [ADDR_W-1:0]    aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 aw_got_q;
    logic                 w_got_q;
    logic                 do_wr;
    epw_reg_t             wr_reg;
    epw_reg_t             rd_reg;
    logic [2:0]           wr_idx;
    logic [2:0]           rd_idx;
    logic [31:0]          rd_word;
    logic [NUM_OUT-1:0]   over_v;
    logic [NUM_OUT-1:0]   eq_v;
    logic [8:0]           gap_q;
    logic [16:0]          per_q;

    // Map a byte address to a register kind and duty index
    function automatic epw_reg_t decode(input logic [ADDR_W-1:0] a);
        epw_reg_t r;
        r = EPW_R_NONE;
        if (a == ADDR_W'(`EPW_PRESCALE_ADDR)) begin
            r = EPW_R_PRESCALE;
        end else if (a == ADDR_W'(`EPW_CYCLE_ADDR)) begin
            r = EPW_R_CYCLE;
        end else if (a == ADDR_W'(`EPW_POLARITY_ADDR)) begin
            r = EPW_R_POLARITY;
        end else if (a == ADDR_W'(`EPW_CONTROL_ADDR)) begin
            r = EPW_R_CONTROL;
        end else if (a >= ADDR_W'(`EPW_DUTY0_ADDR) && a[1:0] == 2'h0
                     && a < ADDR_W'(`EPW_DUTY0_ADDR + 4 * NUM_OUT)) begin
            r = EPW_R_DUTY;
        end
        return r;
    endfunction : decode

    function automatic logic [2:0] duty_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - ADDR_W'(`EPW_DUTY0_ADDR);
        return d[4:2];
    endfunction : duty_index

    assign wr_reg = decode(aw_addr_q);
    assign rd_reg = decode(s_axi_araddr_i);
    assign wr_idx = duty_index(aw_addr_q);
    assign rd_idx = duty_index(s_axi_araddr_i);
    assign do_wr  = aw_got_q && w_got_q && !s_axi_bvalid_o;

    // Write address and data channels, taken in either order
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            aw_got_q        <= 1'b0;
            w_got_q         <= 1'b0;
            aw_addr_q       <= '0;
            w_data_q        <= 32'h0000_0000;
            w_strb_q        <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                s_axi_awready_o <= 1'b0;
                aw_got_q        <= 1'b1;
                aw_addr_q       <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                s_axi_wready_o <= 1'b0;
                w_got_q        <= 1'b1;
                w_data_q       <= s_axi_wdata_i;
                w_strb_q       <= s_axi_wstrb_i;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
                aw_got_q        <= 1'b0;
                w_got_q         <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `EPW_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_reg == EPW_R_NONE) ? `EPW_RESP_SLVERR : `EPW_RESP_OKAY;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Control registers; writes accepted in every power mode
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctl_q.prescale <= `EPW_PRESCALE_RST;
            ctl_q.cycle    <= `EPW_CYCLE_RST;
            ctl_q.polarity <= `EPW_POLARITY_RST;
            ctl_q.power_mode_bit      <= `EPW_PWR_RST;
        end else if (do_wr && w_strb_q[0]) begin
            case (wr_reg)
                EPW_R_PRESCALE: ctl_q.prescale <= w_data_q[7:0];
                EPW_R_CYCLE:    ctl_q.cycle    <= w_data_q[7:0];
                EPW_R_POLARITY: ctl_q.polarity <= w_data_q[7:0];
                EPW_R_CONTROL:  ctl_q.power_mode_bit      <= w_data_q[`EPW_PWR_BIT];
                default:        ctl_q          <= ctl_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < NUM_OUT; i++) begin
            if (rst_i) begin
                duty_value_q[i] <= `EPW_DUTY_RST;
            end else if (do_wr && w_strb_q[0] && wr_reg == EPW_R_DUTY && wr_idx == 3'(i)) begin
                duty_value_q[i] <= w_data_q[7:0];
            end
        end
    end

    // Read data
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_reg)
            EPW_R_PRESCALE: rd_word[7:0] = ctl_q.prescale;
            EPW_R_CYCLE:    rd_word[7:0] = ctl_q.cycle;
            EPW_R_DUTY:     rd_word[7:0] = duty_value_q[rd_idx];
            EPW_R_POLARITY: rd_word[7:0] = ctl_q.polarity;
            EPW_R_CONTROL:  rd_word[`EPW_PWR_BIT] = ctl_q.power_mode_bit;
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= `EPW_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_word;
            s_axi_rresp_o   <= (rd_reg == EPW_R_NONE) ? `EPW_RESP_SLVERR : `EPW_RESP_OKAY;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end
    end

    // Prescaler: one tick every prescale+1 clocks
    assign tick = ctl_q.power_mode_bit && (pre_cnt_q == ctl_q.prescale);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !ctl_q.power_mode_bit) begin
            pre_cnt_q <= 8'h00;
        end else if (tick) begin
            pre_cnt_q <= 8'h00;
        end else begin
            pre_cnt_q <= pre_cnt_q + 8'h01;
        end
    end

    // Shared down-counter; low power parks it at the cycle length
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_q <= `EPW_CYCLE_RST;
        end else if (!ctl_q.power_mode_bit) begin
            cnt_q <= ctl_q.cycle;
        end else if (tick) begin
            cnt_q <= (cnt_q == 8'h00) ? ctl_q.cycle : cnt_q - 8'h01;
        end
    end

    // Per output compare and polarity
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            raw[i] = (cnt_q <= duty_value_q[i]) && (duty_value_q[i] <= ctl_q.cycle);
            over_v[i] = duty_value_q[i] > ctl_q.cycle;
            eq_v[i]   = duty_value_q[i] == ctl_q.cycle;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pulse_out_o <= '0;
        end else if (ctl_q.power_mode_bit) begin
            pulse_out_o <= raw ^ ctl_q.polarity[NUM_OUT-1:0];
        end else begin
            pulse_out_o <= ctl_q.polarity[NUM_OUT-1:0];
        end
    end

    // Check-only: clocks since the last prescaler tick, 0 while unknown
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gap_q <= 9'h000;
        end else if (!ctl_q.power_mode_bit) begin
            gap_q <= 9'h001;
        end else if (do_wr && w_strb_q[0] && wr_reg == EPW_R_PRESCALE) begin
            gap_q <= 9'h000;
        end else if (tick) begin
            gap_q <= 9'h001;
        end else if (gap_q != 9'h000) begin
            gap_q <= gap_q + 9'h001;
        end
    end

    // Check-only: clocks since the last counter wrap, 0 while unknown
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            per_q <= 17'h00000;
        end else if (!ctl_q.power_mode_bit) begin
            per_q <= 17'h00001;
        end else if (do_wr && w_strb_q[0] && (wr_reg == EPW_R_PRESCALE || wr_reg == EPW_R_CYCLE)) begin
            per_q <= 17'h00000;
        end else if (tick && cnt_q == 8'h00) begin
            per_q <= 17'h00001;
        end else if (per_q != 17'h00000) begin
            per_q <= per_q + 17'h00001;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Generator checks
    reset_values_a: assert property (disable iff (1'b0) $fell(rst_i) |-> ctl_q.prescale == `EPW_PRESCALE_RST
        && ctl_q.cycle == `EPW_CYCLE_RST && duty_value_q[0] == `EPW_DUTY_RST && !ctl_q.power_mode_bit && pulse_out_o == '0)
        else $error("register or output reset value wrong");
    tick_spacing_a: assert property (tick && gap_q != 9'h000 |-> gap_q == 9'(ctl_q.prescale) + 9'h001)
        else $error("prescaler tick spacing not prescale plus one");
    period_len_a: assert property (tick && cnt_q == 8'h00 && per_q != 17'h00000 |->
        per_q == (17'(ctl_q.prescale) + 17'h00001) * (17'(ctl_q.cycle) + 17'h00001))
        else $error("output period not prescale plus one times length plus one");
    counter_reload_a: assert property (tick && cnt_q == 8'h00 |=> cnt_q == $past(ctl_q.cycle))
        else $error("down-counter did not reload");
    counter_step_a: assert property (tick && cnt_q != 8'h00 |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("down-counter did not step by one");
    counter_hold_a: assert property (ctl_q.power_mode_bit && !tick |=> $stable(cnt_q))
        else $error("down-counter moved between ticks");
    low_power_rest_a: assert property (!ctl_q.power_mode_bit |=> pulse_out_o == $past(ctl_q.polarity[NUM_OUT-1:0]))
        else $error("low power output not at rest level");
    low_power_park_a: assert property (!ctl_q.power_mode_bit |=> cnt_q == $past(ctl_q.cycle) && pre_cnt_q == 8'h00)
        else $error("low power did not park the counters");
    low_power_regs_a: assert property (!ctl_q.power_mode_bit && !$past(ctl_q.power_mode_bit) && !do_wr |=>
        $stable(ctl_q) && $stable(pre_cnt_q))
        else $error("state changed in low power without a write");
    invert_out_a: assert property (ctl_q.power_mode_bit |=> pulse_out_o == ($past(raw) ^ $past(ctl_q.polarity[NUM_OUT-1:0])))
        else $error("output not raw waveform xor polarity");
    over_duty_low_a: assert property (ctl_q.power_mode_bit |=>
        ((pulse_out_o ^ $past(ctl_q.polarity[NUM_OUT-1:0])) & $past(over_v)) == '0)
        else $error("duty above length not low");
    equal_duty_high_a: assert property (ctl_q.power_mode_bit && cnt_q <= ctl_q.cycle |=>
        ((pulse_out_o ^ $past(ctl_q.polarity[NUM_OUT-1:0])) & $past(eq_v)) == $past(eq_v))
        else $error("duty equal to length not high");
    // Bus handshake and register write checks
    wr_resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before taken");
    rd_resp_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read response dropped before taken");
    wr_refused_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write channels ready while response pending");
    rd_refused_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address ready while read data pending");
    write_resp_a: assert property (do_wr |=> s_axi_bvalid_o)
        else $error("write response not raised after address and data");
    write_lands_a: assert property (do_wr && w_strb_q[0] && wr_reg == EPW_R_PRESCALE |=>
        ctl_q.prescale == $past(w_data_q[7:0]))
        else $error("prescale write did not land");
    strobe_off_a: assert property (do_wr && !w_strb_q[0] |=> $stable(ctl_q))
        else $error("write with low byte strobe off changed a register");

    cycle_wrap_c: cover property (tick && cnt_q == 8'h00 ##1 cnt_q == ctl_q.cycle);
    inverted_run_c: cover property (ctl_q.power_mode_bit && ctl_q.polarity[0] && raw[0]);
    enter_low_power_c: cover property ($fell(ctl_q.power_mode_bit));
    bad_addr_c: cover property (s_axi_bvalid_o && s_axi_bresp_o == `EPW_RESP_SLVERR);
    full_period_c: cover property (tick && cnt_q == 8'h00 && per_q != 17'h00000);

endmodule : epw_top

// [dv/test_eight_channel_pwm.sv]
// Purpose: self-checking bench for the eight output pulse width modulator
// Assumes: AXI4-Lite access, byte addresses from epw_cfg.svh
// Notes:   high time per output is counted over exactly one output period
`timescale 1ns/1ps
`include "epw_cfg.svh"

module test_eight_channel_pwm
    import epw_pkg::*;
;
    logic        clk_sys_i, rst_i;
    logic [15:0] awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  pulse_out_o;
    logic [7:0]  duty_tab [8] = '{8'h00, 8'h03, 8'h04, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07};
    logic [7:0]  pol = 8'h81;
    int          miscompares = 0;
    int          num_checks = 0;

    epw_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pulse_out_o(pulse_out_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic fail(input string msg);
        miscompares++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("response %h expected %h", got, exp));
    endtask : chk_resp

    task automatic chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp) fail($sformatf("high count %0d expected %0d", got, exp));
    endtask : chk_count

    // Address and data offered together; each dropped when its own ready is seen
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] exp);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h000000, d};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk_sys_i);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
            if (++n > 50) begin
                fail("write timeout");
                test_done();
            end
        end
        bready <= 1'b0;
        chk_resp(bresp, exp);
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk_sys_i);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
            if (++n > 50) begin
                fail("read timeout");
                test_done();
            end
        end
        rready <= 1'b0;
        chk_data(rdata, exp);
        chk_resp(rresp, exp_resp);
    endtask : axi_rd

    // Period and timing registers are only changed in low power
    task automatic run_cfg(input logic [7:0] ps, input logic [7:0] cy);
        int per;
        int hi [8];
        int exp;
        axi_wr(`EPW_CONTROL_ADDR, 8'h00, `EPW_RESP_OKAY);
        axi_wr(`EPW_PRESCALE_ADDR, ps, `EPW_RESP_OKAY);
        axi_wr(`EPW_CYCLE_ADDR, cy, `EPW_RESP_OKAY);
        axi_wr(`EPW_CONTROL_ADDR, 8'h01, `EPW_RESP_OKAY);
        per = (int'(ps) + 1) * (int'(cy) + 1);
        repeat (2 * per + 4) @(posedge clk_sys_i);
        hi = '{default: 0};
        repeat (per) begin
            @(negedge clk_sys_i);
            for (int i = 0; i < 8; i++) hi[i] += (pulse_out_o[i] === 1'b1) ? 1 : 0;
        end
        for (int i = 0; i < 8; i++) begin
            exp = (duty_tab[i] > cy) ? 0 : (int'(duty_tab[i]) + 1) * (int'(ps) + 1);
            if (pol[i]) exp = per - exp;
            chk_count(hi[i], exp);
        end
        $display("test period %0d done", per);
    endtask : run_cfg

    initial begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        axi_rd(`EPW_PRESCALE_ADDR, 32'h00000000, `EPW_RESP_OKAY);
        axi_rd(`EPW_CYCLE_ADDR, 32'h000000FF, `EPW_RESP_OKAY);
        for (int i = 0; i < 8; i++) axi_rd(`EPW_DUTY0_ADDR + 16'(4 * i), 32'h00000000, `EPW_RESP_OKAY);
        axi_rd(16'hFD40, 32'h00000000, `EPW_RESP_SLVERR);
        axi_wr(16'hFD40, 8'h55, `EPW_RESP_SLVERR);
        @(negedge clk_sys_i);
        chk_data({24'h000000, pulse_out_o}, 32'h00000000);
        $display("test reset done");
        for (int i = 0; i < 8; i++) axi_wr(`EPW_DUTY0_ADDR + 16'(4 * i), duty_tab[i], `EPW_RESP_OKAY);
        axi_wr(`EPW_POLARITY_ADDR, pol, `EPW_RESP_OKAY);
        wstrb <= 4'hE;
        axi_wr(`EPW_DUTY0_ADDR + 16'h0008, 8'hAA, `EPW_RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(`EPW_DUTY0_ADDR + 16'h0008, 32'h00000004, `EPW_RESP_OKAY);
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk_data({24'h000000, pulse_out_o}, {24'h000000, pol});
        run_cfg(8'h01, 8'h03);
        run_cfg(8'h00, 8'h01);
        run_cfg(8'h02, 8'h05);
        axi_wr(`EPW_CONTROL_ADDR, 8'h00, `EPW_RESP_OKAY);
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk_data({24'h000000, pulse_out_o}, {24'h000000, pol});
        axi_rd(`EPW_DUTY0_ADDR + 16'h0008, 32'h00000004, `EPW_RESP_OKAY);
        axi_rd(`EPW_PRESCALE_ADDR, 32'h00000002, `EPW_RESP_OKAY);
        axi_rd(`EPW_POLARITY_ADDR, {24'h000000, pol}, `EPW_RESP_OKAY);
        axi_rd(`EPW_CONTROL_ADDR, 32'h00000000, `EPW_RESP_OKAY);
        $display("test low power done");
        test_done();
    end
endmodule : test_eight_channel_pwm
